// >>> rtl/sdram_timing_defs.svh
`ifndef SDRAM_TIMING_DEFS_SVH
`define SDRAM_TIMING_DEFS_SVH

// ----------------------------------------
// clock and geometry
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define NUM_BANKS 4
`define BANK_AW 2
`define TMR_W 8

// ----------------------------------------
// burst and latency
// ----------------------------------------
`define BURST_LEN 4
`define BURST_CW 2
`define READ_LATENCY 2

// ----------------------------------------
// interval times in ns
// ----------------------------------------
`define ROW_TO_COLUMN_DELAY_NS 20
`define ROW_PRECHARGE_TIME_NS 20
`define WRITE_RECOVERY_TIME_NS 15
`define REFRESH_CYCLE_TIME_NS 66
`define SELF_REFRESH_EXIT_TIME_NS 75

// ----------------------------------------
// interval times in cycles, least times rounded up
// ----------------------------------------
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RCD_CYC `NS_TO_CYC(`ROW_TO_COLUMN_DELAY_NS)
`define RP_CYC `NS_TO_CYC(`ROW_PRECHARGE_TIME_NS)
`define WR_CYC `NS_TO_CYC(`WRITE_RECOVERY_TIME_NS)
`define RFC_CYC `NS_TO_CYC(`REFRESH_CYCLE_TIME_NS)
`define XSR_CYC `NS_TO_CYC(`SELF_REFRESH_EXIT_TIME_NS)

`endif

// >>> rtl/sdram_types_pkg.sv
package sdram_types_pkg;

  // ----------------------------------------
  // decoded commands
  // ----------------------------------------
  typedef enum logic [3:0] {
    C_INH = 4'h0,
    C_NOP = 4'h1,
    C_ACT = 4'h2,
    C_RD  = 4'h3,
    C_WR  = 4'h4,
    C_PRE = 4'h5,
    C_REF = 4'h6,
    C_LMR = 4'h7,
    C_BST = 4'h8
  } cmd_e;

  // ----------------------------------------
  // per-bank states
  // ----------------------------------------
  typedef enum logic [3:0] {
    B_IDLE   = 4'h0,
    B_ACTV   = 4'h1,
    B_ROW    = 4'h2,
    B_READ   = 4'h3,
    B_WRITE  = 4'h4,
    B_RD_AP  = 4'h5,
    B_WR_AP  = 4'h6,
    B_PRE    = 4'h7,
    B_WR_REC = 4'h8
  } bank_state_e;

  // ----------------------------------------
  // clock-enable power states
  // ----------------------------------------
  typedef enum logic [2:0] {
    P_RUN  = 3'h0,
    P_PDN  = 3'h1,
    P_SREF = 3'h2,
    P_SUSP = 3'h3,
    P_XSR  = 3'h4,
    P_REF  = 3'h5
  } power_e;

endpackage

// >>> rtl/bank_fsm.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_timing_defs.svh"

module bank_fsm import sdram_types_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // commands steered to this bank
  input wire logic adv,
  input wire logic act,
  input wire logic rd,
  input wire logic wr,
  input wire logic pre,
  input wire logic ap,
  input wire logic stop,
  // bank state
  output var bank_state_e state
);

  typedef struct packed {
    bank_state_e st;
    logic [`TMR_W-1:0] tmr;
  } bank_s;

  bank_s s;
  bank_s n;

  assign state = s.st;

  always_comb begin
    n = s;
    if (adv) begin
      unique case (s.st)
        B_IDLE: begin
          if (act) begin
            n.st = B_ACTV;
            n.tmr = `TMR_W'(`RCD_CYC - 1);
          end
        end
        B_ACTV: begin
          if (s.tmr == '0) n.st = B_ROW;
          else n.tmr = s.tmr - 1'b1;
        end
        B_ROW, B_READ, B_WRITE: begin
          if (rd) begin
            n.st = ap ? B_RD_AP : B_READ;
          end else if (wr) begin
            n.st = ap ? B_WR_AP : B_WRITE;
          end else if (pre) begin
            n.st = B_PRE;
            n.tmr = `TMR_W'(`RP_CYC - 1);
          end else if (stop) begin
            n.st = B_ROW;
          end
        end
        B_RD_AP: begin
          if (stop) begin
            n.st = B_PRE;
            n.tmr = `TMR_W'(`RP_CYC - 1);
          end
        end
        B_WR_AP: begin
          if (stop) begin
            n.st = B_WR_REC;
            n.tmr = `TMR_W'(`WR_CYC - 1);
          end
        end
        B_WR_REC: begin
          if (s.tmr == '0) begin
            n.st = B_PRE;
            n.tmr = `TMR_W'(`RP_CYC - 1);
          end else begin
            n.tmr = s.tmr - 1'b1;
          end
        end
        B_PRE: begin
          if (s.tmr == '0) n.st = B_IDLE;
          else n.tmr = s.tmr - 1'b1;
        end
        default: begin
          n.st = B_IDLE;
          n.tmr = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule // bank_fsm

`default_nettype wire

// >>> rtl/sdram_bank_core.sv
// Functional notes
// - decode select, row, column strobe and write enable into commands
// - with bank n idle, bank m takes whatever its own state allows
// - cross-bank command runs only if target bank state supports it
// - burst terminate acts only on the bank with the current burst
// - auto-precharge bank busy until precharge time met, then idle
// - interrupted auto-precharge burst starts its own precharge
// - precharge to another bank leaves current burst running
// - new read's data replaces old burst after read latency
// - read over auto-precharge read starts that bank's precharge
// - read stops write; last write datum one clock earlier
// - write to another bank cuts current write burst off
// - interrupted auto-precharge write: recovery, then precharge
// - clock enable previous and current edge pick the power action
// - enable falling: power-down, self refresh or clock suspend
// - power-down exit gives all-banks-idle by the next edge
// - leaving suspend resumes; next command taken one edge later
// - in self refresh every input but clock enable is ignored
`timescale 1ns/1ps
`default_nettype none
`include "sdram_timing_defs.svh"

module sdram_bank_core import sdram_types_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`BANK_AW-1:0] ba,
  input wire logic ap,
  // command status
  output logic cmd_accept,
  output logic cmd_error,
  output logic all_idle,
  output power_e power_state,
  output bank_state_e bank_state [`NUM_BANKS],
  // data strobes
  output logic rd_data_valid,
  output logic [`BANK_AW-1:0] rd_data_bank,
  output logic wr_data_take,
  output logic [`BANK_AW-1:0] wr_data_bank
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic cmd_e decode(input logic cs, input logic ras, input logic cas,
                                  input logic we);
    cmd_e c;
    c = C_INH;
    if (!cs) begin
      unique case ({ras, cas, we})
        3'h7: c = C_NOP;
        3'h3: c = C_ACT;
        3'h5: c = C_RD;
        3'h4: c = C_WR;
        3'h2: c = C_PRE;
        3'h1: c = C_REF;
        3'h0: c = C_LMR;
        3'h6: c = C_BST;
      endcase
    end
    return c;
  endfunction

  function automatic logic allows(input bank_state_e st, input cmd_e c);
    logic ok;
    ok = 1'b0;
    unique case (c)
      C_ACT: ok = (st == B_IDLE);
      C_RD, C_WR: ok = (st == B_ROW) || (st == B_READ) || (st == B_WRITE);
      C_PRE: ok = (st == B_IDLE) || (st == B_ROW) || (st == B_READ) || (st == B_WRITE);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    power_e ps;
    logic cke_prev;
    logic [`TMR_W-1:0] tmr;
    logic b_act;
    logic b_rd;
    logic [`BANK_AW-1:0] b_bank;
    logic [`BURST_CW-1:0] b_cnt;
    logic [`READ_LATENCY-1:0] pv;
    logic [`READ_LATENCY-1:0][`BANK_AW-1:0] pb;
    logic wr_take;
    logic [`BANK_AW-1:0] wr_bank;
    logic accept;
    logic error;
    logic all_idle;
  } core_s;

  core_s s;
  core_s n;
  cmd_e cmd;
  logic go;
  logic adv;
  logic idle_all;
  logic beat;
  logic [`BANK_AW-1:0] beat_bank;
  logic [`NUM_BANKS-1:0] act_v;
  logic [`NUM_BANKS-1:0] rd_v;
  logic [`NUM_BANKS-1:0] wr_v;
  logic [`NUM_BANKS-1:0] pre_v;
  logic [`NUM_BANKS-1:0] stop_v;
  bank_state_e bst [`NUM_BANKS];

  // ----------------------------------------
  // per-bank state machines
  // ----------------------------------------
  for (genvar i = 0; i < `NUM_BANKS; i++) begin : g_bank
    bank_fsm u_bank (
      .mclk(mclk),
      .resetn(resetn),
      .adv(adv),
      .act(act_v[i]),
      .rd(rd_v[i]),
      .wr(wr_v[i]),
      .pre(pre_v[i]),
      .ap(ap),
      .stop(stop_v[i]),
      .state(bst[i])
    );
    assign bank_state[i] = bst[i];
  end

  // ----------------------------------------
  // command and power logic
  // ----------------------------------------
  always_comb begin
    n = s;
    go = 1'b0;
    beat = 1'b0;
    beat_bank = s.b_bank;
    act_v = '0;
    rd_v = '0;
    wr_v = '0;
    pre_v = '0;
    stop_v = '0;
    n.accept = 1'b0;
    n.error = 1'b0;
    n.wr_take = 1'b0;
    cmd = decode(cs_n, ras_n, cas_n, we_n);
    idle_all = 1'b1;
    for (int i = 0; i < `NUM_BANKS; i++) begin
      if (bst[i] != B_IDLE) idle_all = 1'b0;
    end
    n.all_idle = idle_all;
    n.cke_prev = cke;

    unique case (s.ps)
      P_RUN: begin
        if (s.cke_prev && !cke) begin
          if (idle_all && (cmd == C_INH || cmd == C_NOP)) begin
            n.ps = P_PDN;
          end else if (idle_all && cmd == C_REF) begin
            n.ps = P_SREF;
          end else if (s.b_act && cmd != C_INH) begin
            n.ps = P_SUSP;
          end
        end else if (s.cke_prev && cke) begin
          // commands need enable high at this and the previous edge
          go = 1'b1;
        end
      end
      P_PDN: begin
        if (cke) n.ps = P_RUN;
      end
      P_SREF: begin
        if (cke) begin
          n.ps = P_XSR;
          n.tmr = `TMR_W'(`XSR_CYC - 1);
        end
      end
      // resume, command at exit edge dropped
      P_SUSP: begin
        if (cke) n.ps = P_RUN;
      end
      P_XSR: begin
        if (s.tmr == '0) n.ps = P_RUN;
        else n.tmr = s.tmr - 1'b1;
      end
      P_REF: begin
        if (s.tmr == '0) n.ps = P_RUN;
        else n.tmr = s.tmr - 1'b1;
      end
      default: begin
        n.ps = P_RUN;
      end
    endcase
    adv = (s.ps != P_SUSP) && (n.ps != P_SUSP);

    if (go) begin
      // target judged on its own state
      if (!allows(bst[ba], cmd)) begin
        n.error = 1'b1;
      end else begin
        unique case (cmd)
          C_ACT: begin
            act_v[ba] = 1'b1;
            n.accept = 1'b1;
          end
          C_RD, C_WR: begin
            rd_v[ba] = (cmd == C_RD);
            wr_v[ba] = (cmd == C_WR);
            if (s.b_act && s.b_bank != ba) stop_v[s.b_bank] = 1'b1;
            n.b_act = (`BURST_LEN > 1);
            n.b_rd = (cmd == C_RD);
            n.b_bank = ba;
            n.b_cnt = `BURST_CW'(1);
            beat = 1'b1;
            beat_bank = ba;
            n.accept = 1'b1;
          end
          C_PRE: begin
            n.accept = 1'b1;
            for (int i = 0; i < `NUM_BANKS; i++) begin
              if ((ap || ba == `BANK_AW'(i)) && bst[i] != B_IDLE) pre_v[i] = 1'b1;
            end
            if (s.b_act && pre_v[s.b_bank]) n.b_act = 1'b0;
          end
          C_REF: begin
            if (idle_all) begin
              n.ps = P_REF;
              n.tmr = `TMR_W'(`RFC_CYC - 1);
              n.accept = 1'b1;
            end else begin
              n.error = 1'b1;
            end
          end
          C_LMR: begin
            n.accept = idle_all;
            n.error = !idle_all;
          end
          C_BST: begin
            if (s.b_act) begin
              stop_v[s.b_bank] = 1'b1;
              n.b_act = 1'b0;
              n.accept = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      // continue running burst
      if (!beat && n.b_act) begin
        beat = 1'b1;
        beat_bank = s.b_bank;
        n.b_cnt = s.b_cnt + 1'b1;
        if (s.b_cnt == `BURST_CW'(`BURST_LEN - 1)) begin
          n.b_act = 1'b0;
          stop_v[s.b_bank] = 1'b1;
        end
      end
      n.wr_take = beat && !n.b_rd;
      n.wr_bank = beat_bank;
    end

    if (adv) begin
      n.pv = {s.pv[`READ_LATENCY-2:0], beat && n.b_rd && go};
      n.pb = {s.pb[`READ_LATENCY-2:0], beat_bank};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cmd_accept = s.accept;
  assign cmd_error = s.error;
  assign all_idle = s.all_idle;
  assign power_state = s.ps;
  assign rd_data_valid = s.pv[`READ_LATENCY-1];
  assign rd_data_bank = s.pb[`READ_LATENCY-1];
  assign wr_data_take = s.wr_take;
  assign wr_data_bank = s.wr_bank;

endmodule // sdram_bank_core

`default_nettype wire

// >>> dv/core_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_timing_defs.svh"

module core_checker import sdram_types_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`BANK_AW-1:0] ba,
  input wire logic ap,
  // status
  input wire logic cmd_accept,
  input wire logic cmd_error,
  input wire logic all_idle,
  input var power_e power_state,
  input var bank_state_e bank_state [`NUM_BANKS],
  // data strobes
  input wire logic rd_data_valid,
  input wire logic [`BANK_AW-1:0] rd_data_bank,
  input wire logic wr_data_take,
  input wire logic [`BANK_AW-1:0] wr_data_bank
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic cke_q, run, take, rd_c, wr_c, ref_c;
  // first edge after reset counts as enable low
  always_ff @(posedge mclk) cke_q <= resetn && cke;
  assign run = cke_q && power_state == P_RUN;
  assign take = run && cke;
  assign rd_c = !cs_n && ras_n && !cas_n && we_n;
  assign wr_c = !cs_n && ras_n && !cas_n && !we_n;
  assign ref_c = !cs_n && !ras_n && !cas_n && we_n;

  property p_rd_latency;
    take && rd_c ##1 (cmd_accept && cke) |-> ##1 rd_data_valid;
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read beat missing");
  property p_wr_take;
    take && wr_c ##1 cmd_accept |-> wr_data_take && wr_data_bank == $past(ba);
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write datum not taken");
  property p_ap_state;
    take && (rd_c || wr_c) && ap ##1 cmd_accept |-> bank_state[$past(ba)] inside {B_RD_AP, B_WR_AP};
  endproperty
  a_ap_state: assert property (p_ap_state) else $error("auto precharge bank not busy");
  property p_pre_len;
    $rose(bank_state[0] == B_PRE) |-> (bank_state[0] == B_PRE)[*2] ##[1:2] bank_state[0] == B_IDLE;
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("precharge time wrong");
  property p_pdn_exit;
    power_state == P_PDN && cke |=> power_state == P_RUN;
  endproperty
  a_pdn_exit: assert property (p_pdn_exit) else $error("power-down exit late");
  property p_hold_low;
    !cke && !$past(cke) && power_state inside {P_PDN, P_SREF, P_SUSP} |=> $stable(power_state);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("low-power state left");
  property p_sref_entry;
    run && !cke && all_idle && ref_c |=> power_state == P_SREF;
  endproperty
  a_sref_entry: assert property (p_sref_entry) else $error("self refresh not entered");
  property p_refuse;
    take && ref_c && !all_idle |=> cmd_error && !cmd_accept;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refresh with busy bank taken");
endmodule // core_checker

`default_nettype wire

// >>> dv/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module ctrl_model import sdram_types_pkg::*; (
  // clock
  input wire logic mclk,
  // command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic ap
);
  initial begin
    cke = 1'h1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 2'h0;
    ap = 1'h0;
  end

  task automatic issue(input cmd_e c, input logic [1:0] b, input logic a, input logic k);
    @(negedge mclk);
    cke <= k;
    ba <= b;
    ap <= a;
    case (c)
      C_NOP: {cs_n, ras_n, cas_n, we_n} <= 4'h7;
      C_ACT: {cs_n, ras_n, cas_n, we_n} <= 4'h3;
      C_RD: {cs_n, ras_n, cas_n, we_n} <= 4'h5;
      C_WR: {cs_n, ras_n, cas_n, we_n} <= 4'h4;
      C_PRE: {cs_n, ras_n, cas_n, we_n} <= 4'h2;
      C_REF: {cs_n, ras_n, cas_n, we_n} <= 4'h1;
      C_LMR: {cs_n, ras_n, cas_n, we_n} <= 4'h0;
      C_BST: {cs_n, ras_n, cas_n, we_n} <= 4'h6;
      default: {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    endcase
  endtask

  task automatic nops(input int n, input logic k);
    repeat (n) issue(C_NOP, 2'h0, 1'h0, k);
  endtask
endmodule // ctrl_model

`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_timing_defs.svh"

module tb import sdram_types_pkg::*; ;
  localparam logic [1:0] ACC = 2'h2;
  localparam logic [1:0] ERR = 2'h1;
  logic mclk, resetn, cke, cs_n, ras_n, cas_n, we_n, ap;
  logic [1:0] ba, rd_data_bank, wr_data_bank;
  logic cmd_accept, cmd_error, all_idle, rd_data_valid, wr_data_take;
  power_e power_state;
  bank_state_e bank_state [`NUM_BANKS];
  int n_errors = 0;
  int n_checks = 0;
  logic [1:0] res_q[$];
  logic [1:0] rd_q[$];
  logic [1:0] wr_q[$];
  logic [31:0] rnd;

  ctrl_model ctl (.mclk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .ap);
  sdram_bank_core dut (.mclk, .resetn, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .ap,
    .cmd_accept, .cmd_error, .all_idle, .power_state, .bank_state, .rd_data_valid,
    .rd_data_bank, .wr_data_take, .wr_data_bank);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    n_errors += res_q.size() + rd_q.size() + wr_q.size();
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmd(input cmd_e c, input logic [1:0] b, input logic a, input logic [1:0] e);
    ctl.issue(c, b, a, 1'h1);
    res_q.push_back(e);
  endtask
  task automatic beats(input logic rd, input logic [1:0] b, input int n);
    repeat (n) if (rd) rd_q.push_back(b); else wr_q.push_back(b);
  endtask

  initial begin
    mclk = 1'h0;
    forever #(`CLK_PERIOD_NS / 2) mclk = ~mclk;
  end

  // result watcher takes the oldest note per answer
  always @(negedge mclk) begin
    if (resetn === 1'h1 && (cmd_accept === 1'h1 || cmd_error === 1'h1))
      check("answer", {cmd_accept, cmd_error}, res_q.size() > 0 ? res_q.pop_front() : 8'hxx);
    if (resetn === 1'h1 && rd_data_valid === 1'h1)
      check("read bank", rd_data_bank, rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx);
    if (resetn === 1'h1 && wr_data_take === 1'h1)
      check("write bank", wr_data_bank, wr_q.size() > 0 ? wr_q.pop_front() : 8'hxx);
  end

  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    complete_run();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    resetn = 1'h0;
    rnd = 32'h00010cd2;
    repeat (2) @(posedge mclk);
    @(negedge mclk) resetn = 1'h1;
    ctl.nops(1, 1'h1);
    for (int i = 0; i < 4; i++) cmd(C_ACT, i[1:0], 1'h0, ACC);
    ctl.nops(3, 1'h1);
    cmd(C_ACT, 2'h0, 1'h0, ERR);
    cmd(C_REF, 2'h1, 1'h0, ERR);
    cmd(C_LMR, 2'h2, 1'h0, ERR);
    cmd(C_RD, 2'h0, 1'h0, ACC);
    cmd(C_RD, 2'h1, 1'h0, ACC);
    beats(1'h1, 2'h0, 1);
    beats(1'h1, 2'h1, 4);
    ctl.nops(8, 1'h1);
    cmd(C_WR, 2'h2, 1'h0, ACC);
    cmd(C_WR, 2'h3, 1'h0, ACC);
    beats(1'h0, 2'h2, 1);
    beats(1'h0, 2'h3, 4);
    ctl.nops(6, 1'h1);
    // write over read; no data mask pin, read cut at write
    cmd(C_RD, 2'h2, 1'h0, ACC);
    cmd(C_WR, 2'h3, 1'h0, ACC);
    beats(1'h1, 2'h2, 1);
    beats(1'h0, 2'h3, 4);
    ctl.nops(6, 1'h1);
    cmd(C_WR, 2'h2, 1'h0, ACC);
    cmd(C_RD, 2'h3, 1'h0, ACC);
    beats(1'h0, 2'h2, 1);
    beats(1'h1, 2'h3, 4);
    ctl.nops(8, 1'h1);
    cmd(C_RD, 2'h0, 1'h1, ACC);
    cmd(C_RD, 2'h1, 1'h0, ACC);
    cmd(C_PRE, 2'h2, 1'h0, ACC);
    beats(1'h1, 2'h0, 1);
    beats(1'h1, 2'h1, 4);
    ctl.nops(10, 1'h1);
    check("bank0", bank_state[0], B_IDLE);
    cmd(C_WR, 2'h3, 1'h1, ACC);
    cmd(C_WR, 2'h1, 1'h0, ACC);
    beats(1'h0, 2'h3, 1);
    beats(1'h0, 2'h1, 4);
    ctl.nops(10, 1'h1);
    check("bank3", bank_state[3], B_IDLE);
    cmd(C_PRE, 2'h1, 1'h0, ACC);
    ctl.nops(4, 1'h1);
    check("idle", all_idle, 1'h1);
    repeat (3) begin
      cmd(C_ACT, rnd[1:0], 1'h0, ACC);
      ctl.nops(3, 1'h1);
      cmd(C_PRE, rnd[1:0], 1'h0, ACC);
      ctl.nops(3, 1'h1);
      rnd = lfsr(rnd);
    end
    ctl.nops(3, 1'h0);
    check("power", power_state, P_PDN);
    ctl.nops(2, 1'h1);
    check("power", power_state, P_RUN);
    // self refresh ignores junk while enable low
    ctl.issue(C_REF, 2'h0, 1'h0, 1'h0);
    repeat (4) begin
      ctl.issue(cmd_e'({1'h0, rnd[2:0]}), rnd[4:3], rnd[5], 1'h0);
      rnd = lfsr(rnd);
    end
    check("power", power_state, P_SREF);
    ctl.nops(12, 1'h1);
    check("power", power_state, P_RUN);
    // auto refresh with all banks idle
    cmd(C_REF, 2'h0, 1'h0, ACC);
    ctl.nops(9, 1'h1);
    cmd(C_ACT, 2'h0, 1'h0, ACC);
    ctl.nops(3, 1'h1);
    cmd(C_RD, 2'h0, 1'h0, ACC);
    beats(1'h1, 2'h0, 4);
    ctl.nops(3, 1'h0);
    check("power", power_state, P_SUSP);
    ctl.nops(1, 1'h1);
    cmd(C_PRE, 2'h1, 1'h0, ACC);
    ctl.nops(8, 1'h1);
    cmd(C_PRE, 2'h0, 1'h0, ACC);
    ctl.nops(4, 1'h1);
    complete_run();
  end
endmodule // tb

bind sdram_bank_core core_checker u_chk (.mclk, .resetn, .cke, .cs_n, .ras_n, .cas_n, .we_n,
  .ba, .ap, .cmd_accept, .cmd_error, .all_idle, .power_state, .bank_state, .rd_data_valid,
  .rd_data_bank, .wr_data_take, .wr_data_bank);

`default_nettype wire
